// File: core/cdps_top.sv
// socket card detection, supply switch encoding and wishbone registers
`timescale 1ns/1ps
module cdps_top #(
	parameter int unsigned OSC_DIV = cdps_pkg::OSC_DIV,
	parameter int unsigned LINK_DIV = cdps_pkg::LINK_DIV
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic IRQ,
	input wire logic CARD_DETECT_A_I,
	output logic CARD_DETECT_A_O,
	output logic CARD_DETECT_A_OE,
	input wire logic CARD_DETECT_B_I,
	output logic CARD_DETECT_B_O,
	output logic CARD_DETECT_B_OE,
	input wire logic VOLTAGE_SENSE_A_I,
	input wire logic VOLTAGE_SENSE_B_I,
	output logic STATUS_CHANGE_PULLUP,
	output logic STATUS_CHANGE_PULLDOWN,
	output logic SW_CLK,
	output logic SW_DATA,
	output logic SW_LATCH
);
	// ****************************************************************
	// declarations
	// ****************************************************************
	typedef enum logic [3:0] {
		IS_EMPTY = 4'b0001, // waiting for a card
		IS_PROBE_A = 4'b0010, // detect a pulled low
		IS_PROBE_B = 4'b0100, // detect b pulled low
		IS_HOLD = 4'b1000 // class known, watching for removal
	} cdps_itg_e;

	cdps_itg_e st_r, st_nxt; // interrogation state
	cdps_pkg::cdps_sense_s gnd_r, gnd_nxt; // lines found grounded when released
	logic [1:0] la_r, la_nxt; // sense lines tied to detect a {b,a}
	logic [1:0] lb_r, lb_nxt; // sense lines tied to detect b {b,a}
	cdps_pkg::cdps_class_e cls_r, cls_nxt; // decoded card class
	logic oe_a_r, oe_a_nxt; // detect a driven low
	logic oe_b_r, oe_b_nxt; // detect b driven low
	logic pu_r, pu_nxt; // status change pull-up
	logic pd_r, pd_nxt; // status change pull-down
	logic [31:0] ctrl_r, ctrl_nxt; // control register
	cdps_pkg::cdps_power_s pow_r, pow_nxt; // supply request
	logic [cdps_pkg::EV_W-1:0] ev_r, ev_nxt; // sticky events
	logic [cdps_pkg::EV_W-1:0] mask_r, mask_nxt; // interrupt enables
	logic [cdps_pkg::WORD_W-1:0] sent_r, sent_nxt; // word last handed to link
	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic irq_r, irq_nxt;
	logic osc_tick; // slow oscillator enable
	logic link_tick; // serial half-bit enable
	logic link_busy;
	logic link_done;
	logic link_start;
	logic [cdps_pkg::WORD_W-1:0] word; // encoded switch word
	cdps_pkg::cdps_sense_s pins; // live levels, low means pulled down
	logic [cdps_pkg::EV_W-1:0] ev_set; // event pulses this cycle
	logic access; // new bus request
	logic [31:0] wmask; // byte lanes as bit mask
	logic [31:0] present; // present-state read value
	logic is_cb; // cardbus style interface
	logic lv_flag;
	logic xv_flag;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic cdps_pkg::cdps_class_e classify(input cdps_pkg::cdps_sense_s g,
			input logic [1:0] la, input logic [1:0] lb);
		if (g.cd_a && g.cd_b) begin // both detects grounded
			classify = cdps_pkg::CLS_16BIT;
		end else if (la[0]) begin // detect a to sense a
			classify = g.vs_b ? cdps_pkg::CLS_CUSTOM : cdps_pkg::CLS_CB_3V3;
		end else if (la[1]) begin // detect a to sense b
			classify = g.vs_a ? cdps_pkg::CLS_RESERVED : cdps_pkg::CLS_CB_XY;
		end else if (lb[1]) begin // detect b to sense b
			classify = g.vs_a ? cdps_pkg::CLS_CB_3V3_X : cdps_pkg::CLS_CB_1V8_CORE;
		end else if (lb[0]) begin // detect b to sense a
			classify = g.vs_b ? cdps_pkg::CLS_CB_3V3_XY : cdps_pkg::CLS_CB_Y;
		end else begin
			classify = cdps_pkg::CLS_RESERVED; // no legal pattern seen
		end
	endfunction

	// switch word from request and switch type; socket b bits stay at 0 V
	function automatic logic [cdps_pkg::WORD_W-1:0] encode(input logic sel,
			input cdps_pkg::cdps_power_s p);
		logic [2:0] pat;
		pat = cdps_pkg::PAT_0V;
		encode = '0;
		case (p.vpp)
			cdps_pkg::VPP_OFF: pat = cdps_pkg::PAT_0V;
			cdps_pkg::VPP_3V3: pat = cdps_pkg::PAT_3V3;
			cdps_pkg::VPP_5V: pat = cdps_pkg::PAT_5V;
			cdps_pkg::VPP_12V: pat = sel ? cdps_pkg::PAT_T1_12V : cdps_pkg::PAT_T0_HIZ;
			cdps_pkg::VPP_1V8: pat = sel ? cdps_pkg::PAT_T1_HIZ : cdps_pkg::PAT_T0_1V8;
			default: pat = sel ? cdps_pkg::PAT_T1_HIZ : cdps_pkg::PAT_T0_HIZ;
		endcase
		encode[cdps_pkg::D_VPP0] = pat[2];
		encode[cdps_pkg::D_VPP1] = pat[1];
		encode[cdps_pkg::D_VPP2] = pat[0];
		// same main-supply pattern for both types, 11 would also read 0 V
		encode[cdps_pkg::D_VCC_HI] = p.vcc[1];
		encode[cdps_pkg::D_VCC_LO] = p.vcc[0];
		encode[cdps_pkg::D_SWITCH_SHUTDOWN_N] = p.on; // low puts the switch outputs in hi-z
	endfunction

	// ****************************************************************
	// rate dividers and serial link
	// ****************************************************************
	cdps_tick #(.DIV(OSC_DIV)) u_osc (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.tick(osc_tick)
	);

	cdps_tick #(.DIV(LINK_DIV)) u_link_tick (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.tick(link_tick)
	);

	cdps_ser_tx #(.W(cdps_pkg::WORD_W)) u_ser (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.tick(link_tick),
		.start(link_start),
		.word(sent_nxt),
		.sclk(SW_CLK),
		.sdata(SW_DATA),
		.slatch(SW_LATCH),
		.busy(link_busy),
		.done(link_done)
	);

	// ****************************************************************
	// interrogation, paced by the slow tick only
	// ****************************************************************
	always_comb begin
		pins = '{cd_b: CARD_DETECT_B_I, cd_a: CARD_DETECT_A_I,
			vs_b: VOLTAGE_SENSE_B_I, vs_a: VOLTAGE_SENSE_A_I};
		st_nxt = st_r;
		gnd_nxt = gnd_r;
		la_nxt = la_r;
		lb_nxt = lb_r;
		cls_nxt = cls_r;
		oe_a_nxt = 1'b0;
		oe_b_nxt = 1'b0;
		ev_set = '0;
		case (st_r)
			IS_EMPTY: begin
				// every card grounds at least one detect line; a powered
				// socket is not cold, so no probe is started then
				if (osc_tick && (!pins.cd_a || !pins.cd_b) && !pow_r.on) begin
					gnd_nxt = ~pins;
					oe_a_nxt = pins.cd_a; // drive only an undriven line
					st_nxt = IS_PROBE_A;
					ev_set[cdps_pkg::EV_INSERT] = 1'b1;
				end
			end
			IS_PROBE_A: begin
				oe_a_nxt = !gnd_r.cd_a;
				if (osc_tick) begin // sense lines that followed detect a
					la_nxt = {!pins.vs_b && !gnd_r.vs_b, !pins.vs_a && !gnd_r.vs_a};
					oe_a_nxt = 1'b0;
					oe_b_nxt = !gnd_r.cd_b;
					st_nxt = IS_PROBE_B;
				end
			end
			IS_PROBE_B: begin
				oe_b_nxt = !gnd_r.cd_b;
				if (osc_tick) begin
					lb_nxt = {!pins.vs_b && !gnd_r.vs_b, !pins.vs_a && !gnd_r.vs_a};
					cls_nxt = classify(gnd_r, la_r, lb_nxt);
					oe_b_nxt = 1'b0;
					st_nxt = IS_HOLD;
					ev_set[cdps_pkg::EV_DETECT] = 1'b1;
				end
			end
			IS_HOLD: begin
				if (osc_tick && pins.cd_a && pins.cd_b) begin // card pulled
					cls_nxt = cdps_pkg::CLS_NONE;
					gnd_nxt = '0;
					la_nxt = '0;
					lb_nxt = '0;
					st_nxt = IS_EMPTY;
					ev_set[cdps_pkg::EV_REMOVE] = 1'b1;
				end
			end
			default: begin
				st_nxt = IS_EMPTY;
			end
		endcase
		ev_set[cdps_pkg::EV_SENT] = link_done;
		is_cb = (cls_r != cdps_pkg::CLS_NONE) && (cls_r != cdps_pkg::CLS_16BIT);
		pu_nxt = (cls_r == cdps_pkg::CLS_16BIT);
		pd_nxt = is_cb;
		// low voltage or extra voltage flag, chosen by switch type
		lv_flag = (cls_r == cdps_pkg::CLS_CB_1V8_CORE) && !ctrl_r[cdps_pkg::CTRL_SW_SEL];
		xv_flag = (cls_r == cdps_pkg::CLS_CB_1V8_CORE) && ctrl_r[cdps_pkg::CTRL_SW_SEL];
	end

	// ****************************************************************
	// register file and wishbone slave, one wait state per access
	// ****************************************************************
	always_comb begin
		access = WB_CYC_I && WB_STB_I && !ack_r;
		wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
		present = cdps_pkg::RST_WORD;
		present[cdps_pkg::PRES_CLASS_LSB +: 4] = cls_r;
		present[cdps_pkg::PRES_CARD] = (st_r != IS_EMPTY);
		present[cdps_pkg::PRES_16BIT] = pu_r;
		present[cdps_pkg::PRES_CB] = pd_r;
		present[cdps_pkg::PRES_LV] = lv_flag;
		present[cdps_pkg::PRES_XV] = xv_flag;
		present[cdps_pkg::PRES_PROBE] = (st_r == IS_PROBE_A) || (st_r == IS_PROBE_B);
		present[cdps_pkg::PRES_LINK] = link_busy;
		present[cdps_pkg::PRES_VS_LSB +: 2] = {gnd_r.vs_b, gnd_r.vs_a};
		present[cdps_pkg::PRES_WORD_LSB +: cdps_pkg::WORD_W] = sent_r;
		ack_nxt = access;
		dat_nxt = cdps_pkg::RST_WORD; // unmapped reads return zero
		ctrl_nxt = ctrl_r;
		pow_nxt = pow_r;
		mask_nxt = mask_r;
		ev_nxt = ev_r;
		if (access && !WB_WE_I) begin
			case (WB_ADR_I)
				cdps_pkg::ADR_CTRL: dat_nxt = ctrl_r;
				cdps_pkg::ADR_POWER: begin // fields read back where software wrote them
					dat_nxt[cdps_pkg::POW_VCC_LSB +: 2] = pow_r.vcc;
					dat_nxt[cdps_pkg::POW_VPP_LSB +: 3] = pow_r.vpp;
					dat_nxt[cdps_pkg::POW_ON] = pow_r.on;
				end
				cdps_pkg::ADR_PRESENT: dat_nxt = present;
				cdps_pkg::ADR_EVENT: dat_nxt = 32'(ev_r);
				cdps_pkg::ADR_MASK: dat_nxt = 32'(mask_r);
				default: dat_nxt = cdps_pkg::RST_WORD;
			endcase
		end else if (access) begin
			case (WB_ADR_I)
				cdps_pkg::ADR_CTRL: begin // only the type select is writable
					ctrl_nxt[cdps_pkg::CTRL_SW_SEL] = wmask[cdps_pkg::CTRL_SW_SEL] ?
						WB_DAT_I[cdps_pkg::CTRL_SW_SEL] : ctrl_r[cdps_pkg::CTRL_SW_SEL];
				end
				cdps_pkg::ADR_POWER: begin
					if (WB_SEL_I[0]) begin
						pow_nxt.vcc = WB_DAT_I[cdps_pkg::POW_VCC_LSB +: 2];
						pow_nxt.vpp = WB_DAT_I[cdps_pkg::POW_VPP_LSB +: 3];
					end
					if (WB_SEL_I[1]) begin
						pow_nxt.on = WB_DAT_I[cdps_pkg::POW_ON];
					end
				end
				cdps_pkg::ADR_EVENT: ev_nxt = ev_r & ~(WB_DAT_I[cdps_pkg::EV_W-1:0] &
					wmask[cdps_pkg::EV_W-1:0]);
				cdps_pkg::ADR_MASK: begin
					if (WB_SEL_I[0]) begin
						mask_nxt = WB_DAT_I[cdps_pkg::EV_W-1:0];
					end
				end
				default: ev_nxt = ev_r; // unmapped writes are acked and dropped
			endcase
		end
		// removal powers the socket down, winning over a write
		if (ev_set[cdps_pkg::EV_REMOVE]) begin
			pow_nxt.on = 1'b0;
		end
		ev_nxt = ev_nxt | ev_set; // a set beats a clear in the same cycle
		irq_nxt = |(ev_nxt & mask_nxt);
		// a new word goes out once the link is idle; changes meanwhile wait
		word = encode(ctrl_r[cdps_pkg::CTRL_SW_SEL], pow_r);
		link_start = !link_busy && (word != sent_r);
		sent_nxt = link_start ? word : sent_r;
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			st_r <= IS_EMPTY;
			gnd_r <= '0;
			la_r <= '0;
			lb_r <= '0;
			cls_r <= cdps_pkg::CLS_NONE;
			oe_a_r <= 1'b0;
			oe_b_r <= 1'b0;
			pu_r <= 1'b0;
			pd_r <= 1'b0;
			ctrl_r <= cdps_pkg::RST_CTRL;
			pow_r <= '0;
			ev_r <= '0;
			mask_r <= '0;
			sent_r <= '0;
			ack_r <= 1'b0;
			dat_r <= cdps_pkg::RST_WORD;
			irq_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			gnd_r <= gnd_nxt;
			la_r <= la_nxt;
			lb_r <= lb_nxt;
			cls_r <= cls_nxt;
			oe_a_r <= oe_a_nxt;
			oe_b_r <= oe_b_nxt;
			pu_r <= pu_nxt;
			pd_r <= pd_nxt;
			ctrl_r <= ctrl_nxt;
			pow_r <= pow_nxt;
			ev_r <= ev_nxt;
			mask_r <= mask_nxt;
			sent_r <= sent_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ****************************************************************
	// outputs, open-drain detect lines only ever pull low
	// ****************************************************************
	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;
	assign IRQ = irq_r;
	assign CARD_DETECT_A_O = 1'b0;
	assign CARD_DETECT_A_OE = oe_a_r;
	assign CARD_DETECT_B_O = 1'b0;
	assign CARD_DETECT_B_OE = oe_b_r;
	assign STATUS_CHANGE_PULLUP = pu_r;
	assign STATUS_CHANGE_PULLDOWN = pd_r;
endmodule

// File: core/cdps_pkg.sv
// constants, types and field layout shared by the card detect / power switch block
// How it works
// - selector 0 plus 1.8 V core card sets low-voltage flag
// - selector 1 sets extra-voltage flag for that card
// - 3.3 V card with 1.8 V core is own class
// - card in cold socket starts an interrogation
// - detect and sense lines decode interface and voltage
// - custom cards recognised from their own line pattern
// - three-pin serial link, selector picks switch encoding
// - first switch encoding is used after reset
// - first switch programming-supply bit patterns
// - first switch main-supply bit patterns
// - second switch programming-supply bit patterns
// - second switch main-supply patterns match the first
// - slow always-on tick paces interrogation and power-down
// - status-change pin pull follows inserted card interface
package cdps_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_HZ = 125_000_000; // system clock rate
	localparam int unsigned OSC_HZ = 16_000; // nominal slow oscillator rate
	localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ; // rounds down to 7812
	localparam int unsigned LINK_HZ = 1_000_000; // serial link half-bit rate
	localparam int unsigned LINK_DIV = CLK_HZ / LINK_HZ; // 125 cycles

	// ****************************************************************
	// register map, byte addresses
	// ****************************************************************
	localparam logic [7:0] ADR_CTRL = 8'h00; // switch type select
	localparam logic [7:0] ADR_POWER = 8'h04; // supply request
	localparam logic [7:0] ADR_PRESENT = 8'h08; // card state, read only
	localparam logic [7:0] ADR_EVENT = 8'h0C; // sticky events, write one to clear
	localparam logic [7:0] ADR_MASK = 8'h10; // interrupt mask
	localparam int CTRL_SW_SEL = 10; // switch type select bit
	localparam int PRES_CLASS_LSB = 0; // card class, four bits
	localparam int PRES_CARD = 4; // a card sits in the socket
	localparam int PRES_16BIT = 5; // 16-bit card
	localparam int PRES_CB = 6; // cardbus interface
	localparam int PRES_LV = 7; // low voltage card flag
	localparam int PRES_XV = 8; // extra voltage card flag
	localparam int PRES_PROBE = 9; // interrogation running
	localparam int PRES_LINK = 10; // serial link busy
	localparam int PRES_VS_LSB = 12; // grounded sense lines {b,a}
	localparam int PRES_WORD_LSB = 16; // last word sent to the switch
	localparam int EV_INSERT = 0; // card arrived
	localparam int EV_REMOVE = 1; // card left
	localparam int EV_DETECT = 2; // interrogation finished
	localparam int EV_SENT = 3; // switch word latched
	localparam int EV_W = 4; // number of event bits
	localparam logic [31:0] RST_CTRL = 32'h0000_0000; // first switch type
	localparam logic [31:0] RST_WORD = 32'h0000_0000; // zero for reset and unmapped

	// ****************************************************************
	// switch control word D0..D10
	// ****************************************************************
	localparam int WORD_W = 11; // bits in the switch word
	localparam int D_VPP0 = 0; // D0
	localparam int D_VPP1 = 1; // D1
	localparam int D_VCC_LO = 2; // D2
	localparam int D_VCC_HI = 3; // D3
	localparam int D_SWITCH_SHUTDOWN_N = 8; // D8, shutdown, low disables outputs
	localparam int D_VPP2 = 9; // D9
	localparam logic [1:0] VCC_OFF = 2'h0; // request and pattern {D3,D2}
	localparam logic [1:0] VCC_3V3 = 2'h1;
	localparam logic [1:0] VCC_5V = 2'h2;
	localparam logic [2:0] VPP_OFF = 3'h0; // programming supply requests
	localparam logic [2:0] VPP_3V3 = 3'h1;
	localparam logic [2:0] VPP_5V = 3'h2;
	localparam logic [2:0] VPP_12V = 3'h3;
	localparam logic [2:0] VPP_1V8 = 3'h4;
	localparam logic [2:0] VPP_HIZ = 3'h5;
	localparam logic [2:0] PAT_0V = 3'h0; // {D0,D1,D9}
	localparam logic [2:0] PAT_3V3 = 3'h2;
	localparam logic [2:0] PAT_5V = 3'h3;
	localparam logic [2:0] PAT_T0_HIZ = 3'h4;
	localparam logic [2:0] PAT_T0_1V8 = 3'h7;
	localparam logic [2:0] PAT_T1_12V = 3'h4;
	localparam logic [2:0] PAT_T1_HIZ = 3'h6;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [3:0] {
		CLS_NONE = 4'h0,
		CLS_16BIT = 4'h1,
		CLS_CB_3V3 = 4'h2,
		CLS_CB_3V3_X = 4'h3,
		CLS_CB_3V3_XY = 4'h4,
		CLS_CB_1V8_CORE = 4'h5,
		CLS_CB_XY = 4'h6,
		CLS_CB_Y = 4'h7,
		CLS_CUSTOM = 4'h8,
		CLS_RESERVED = 4'h9
	} cdps_class_e;

	typedef struct packed {
		logic cd_b; // card detect b
		logic cd_a; // card detect a
		logic vs_b; // voltage sense b
		logic vs_a; // voltage sense a
	} cdps_sense_s;

	typedef struct packed {
		logic on; // becomes the shutdown bit
		logic [2:0] vpp; // programming supply request
		logic [1:0] vcc; // main supply request
	} cdps_power_s;

	localparam int POW_VCC_LSB = 0; // power register fields
	localparam int POW_VPP_LSB = 4;
	localparam int POW_ON = 8;

endpackage

// File: core/cdps_tick.sv
// divider that makes a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module cdps_tick #(
	parameter int unsigned DIV = 125
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1; // counter width

	logic [CW-1:0] cnt_r; // cycles since last pulse
	logic [CW-1:0] cnt_nxt;
	logic tick_r; // registered pulse
	logic tick_nxt;

	// ****************************************************************
	// next count
	// ****************************************************************
	always_comb begin
		if (cnt_r == CW'(DIV - 1)) begin
			cnt_nxt = '0; // wrap and fire
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
			tick_nxt = 1'b0;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule

// File: core/cdps_ser_tx.sv
// serial shifter for the power switch word: clock, data and latch pins
`timescale 1ns/1ps
module cdps_ser_tx #(
	parameter int W = 11
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic start,
	input wire logic [W-1:0] word,
	output logic sclk,
	output logic sdata,
	output logic slatch,
	output logic busy,
	output logic done
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_LATCH = 3'b100
	} cdps_ser_e;

	localparam int BW = $clog2(W); // bit counter width

	cdps_ser_e st_r, st_nxt; // sequencer state
	logic [W-1:0] sh_r, sh_nxt; // remaining bits, msb out first
	logic [BW-1:0] cnt_r, cnt_nxt; // bits left after this one
	logic ph_r, ph_nxt; // half-bit phase
	logic sclk_r, sclk_nxt;
	logic sdata_r, sdata_nxt;
	logic slatch_r, slatch_nxt;
	logic done_r, done_nxt;

	// ****************************************************************
	// sequencer: data set with clock low, taken on clock rise, then latch
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		ph_nxt = ph_r;
		sclk_nxt = sclk_r;
		sdata_nxt = sdata_r;
		slatch_nxt = slatch_r;
		done_nxt = 1'b0;
		case (st_r)
			ST_IDLE: begin
				if (start) begin
					sh_nxt = word;
					cnt_nxt = BW'(W - 1);
					ph_nxt = 1'b0;
					st_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (tick && !ph_r) begin // present next bit, D10 first
					sclk_nxt = 1'b0;
					sdata_nxt = sh_r[W-1];
					ph_nxt = 1'b1;
				end else if (tick) begin // rising clock edge to the switch
					sclk_nxt = 1'b1;
					sh_nxt = {sh_r[W-2:0], 1'b0};
					ph_nxt = 1'b0;
					if (cnt_r == '0) begin
						st_nxt = ST_LATCH;
					end else begin
						cnt_nxt = cnt_r - 1'b1;
					end
				end
			end
			ST_LATCH: begin
				if (tick && !slatch_r) begin // latch pulse, one half bit
					sclk_nxt = 1'b0;
					slatch_nxt = 1'b1;
				end else if (tick) begin
					slatch_nxt = 1'b0;
					done_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			sh_r <= '0;
			cnt_r <= '0;
			ph_r <= 1'b0;
			sclk_r <= 1'b0;
			sdata_r <= 1'b0;
			slatch_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			ph_r <= ph_nxt;
			sclk_r <= sclk_nxt;
			sdata_r <= sdata_nxt;
			slatch_r <= slatch_nxt;
			done_r <= done_nxt;
		end
	end

	assign sclk = sclk_r;
	assign sdata = sdata_r;
	assign slatch = slatch_r;
	assign busy = (st_r != ST_IDLE);
	assign done = done_r;
endmodule

// File: bench/cdps_checker.sv
// port assertions for the card detect and power switch block
`timescale 1ns/1ps
module cdps_checker (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic [31:0] WB_DAT_O,
	input wire logic CARD_DETECT_A_O,
	input wire logic CARD_DETECT_B_O,
	input wire logic CARD_DETECT_A_OE,
	input wire logic CARD_DETECT_B_OE,
	input wire logic STATUS_CHANGE_PULLUP,
	input wire logic STATUS_CHANGE_PULLDOWN,
	input wire logic SW_CLK,
	input wire logic SW_DATA,
	input wire logic SW_LATCH
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// open request, then a one-cycle answer
	sequence bus_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
	sequence ack_pulse; WB_ACK_O ##1 !WB_ACK_O; endsequence
	ack_once_a: assert property (bus_req |=> ack_pulse) else $error("bad ack");
	ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("stray ack");
	dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000) else $error("data not 0");
	pull_one_a: assert property (!(STATUS_CHANGE_PULLUP && STATUS_CHANGE_PULLDOWN))
		else $error("two pulls");
	probe_one_a: assert property (!(CARD_DETECT_A_OE && CARD_DETECT_B_OE))
		else $error("two probes");
	pull_low_a: assert property (!(CARD_DETECT_A_O || CARD_DETECT_B_O))
		else $error("detect driven high");
	latch_low_a: assert property (SW_LATCH |-> !SW_CLK) else $error("latch with clock");
	bit_hold_a: assert property (SW_CLK && $past(SW_CLK) |-> $stable(SW_DATA))
		else $error("data moved");
	idle_reset_a: assert property ($rose(RST_N) |-> !(SW_CLK || SW_LATCH))
		else $error("busy after reset");
endmodule

// File: bench/cdps_far.sv
// card wiring and power switch receiver on the far side of the block
`timescale 1ns/1ps
module cdps_far (
	input wire logic present,
	input wire logic [11:0] card,
	input wire logic oe_a,
	input wire logic oe_b,
	input wire logic sw_clk,
	input wire logic sw_data,
	input wire logic sw_latch,
	output logic cd_a,
	output logic cd_b,
	output logic vs_a,
	output logic vs_b,
	output logic [10:0] word
);
	logic [10:0] shift_r; // bits taken so far
	// card[11:8] grounds cd_b cd_a vs_b vs_a; [7:6] and [5:4] tie vs_a, vs_b (1 to a, 2 to b)
	// open lines float high, so a tied sense line only reads low while its detect is pulled
	always_comb begin
		cd_b = !(present && card[11]) && !oe_b;
		cd_a = !(present && card[10]) && !oe_a;
		vs_b = !(present && (card[9] || |(card[5:4] & {oe_b, oe_a})));
		vs_a = !(present && (card[8] || |(card[7:6] & {oe_b, oe_a})));
	end
	// switch takes data on the clock rise, D10 first
	always @(posedge sw_clk) shift_r <= {shift_r[9:0], sw_data};
	// latch strobe moves the collected word out
	always @(posedge sw_latch) word <= shift_r;
endmodule

// File: bench/tb.sv
// bench: every card class on both switch types with supply requests
`timescale 1ns/1ps
module tb;
	localparam logic [23:0] PAT0 = 24'h92_78d0; // first switch vpp pattern per request
	localparam logic [23:0] PAT1 = 24'hdb_68d0; // second switch
	localparam logic [11:0] CARDS [9] = '{12'hd01, 12'h842, 12'h523, 12'h684, 12'h425, 12'h816,
		12'h487, 12'ha48, 12'h919};
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, present = 1'b0, s;
	logic [7:0] adr = 8'h00;
	logic [11:0] card = 12'h000, k;
	logic [31:0] wdat = 32'h0000_0000, seed = 32'h0000_d97f, rdat, q, ev, r;
	logic [10:0] word;
	logic [2:0] p;
	logic ack, irq, cda, cdb, vsa, vsb, oea, oeb, pu, pd, sck, sda, slt;
	int err_total = 0, total_checks = 0;
	always #4 clk = ~clk;
	cdps_top #(.OSC_DIV(8), .LINK_DIV(2)) i_dut (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq), .CARD_DETECT_A_I(cda), .CARD_DETECT_A_O(),
		.CARD_DETECT_A_OE(oea), .CARD_DETECT_B_I(cdb), .CARD_DETECT_B_O(), .CARD_DETECT_B_OE(oeb),
		.VOLTAGE_SENSE_A_I(vsa), .VOLTAGE_SENSE_B_I(vsb), .STATUS_CHANGE_PULLUP(pu),
		.STATUS_CHANGE_PULLDOWN(pd), .SW_CLK(sck), .SW_DATA(sda), .SW_LATCH(slt));
	cdps_far i_far (.present(present), .card(card), .oe_a(oea), .oe_b(oeb), .sw_clk(sck),
		.sw_data(sda), .sw_latch(slt), .cd_a(cda), .cd_b(cdb), .vs_a(vsa), .vs_b(vsb), .word(word));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected word D10..D0: socket b bits stay zero
	function automatic logic [10:0] exp_word(input logic sw, input logic [2:0] v,
		input logic [1:0] c, input logic o);
		logic [2:0] t;
		t = sw ? PAT1[v * 3 +: 3] : PAT0[v * 3 +: 3];
		return {1'b0, t[0], o, 4'h0, c, t[1], t[2]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle, entered just after a clock edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	// poll events, then clear them all; irq follows with every event unmasked
	task automatic wait_ev(input int b);
		ev = 32'h0000_0000;
		for (int i = 0; i < 300 && ev[b] !== 1'b1; i++) begin
			wb(1'b0, cdps_pkg::ADR_EVENT, 32'h0000_0000);
			ev = q;
		end
		chk(ev[b], 1'b1);
		chk(irq, 1'b1);
		wb(1'b1, cdps_pkg::ADR_EVENT, 32'h0000_000f);
		chk(irq, 1'b0);
	endtask
	task automatic test_done();
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin // watchdog, far above the few thousand cycles needed
		#400_000;
		err_total++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, cdps_pkg::ADR_CTRL, 32'h0000_0000);
		chk(q, cdps_pkg::RST_CTRL);
		wb(1'b0, 8'h40, 32'h0000_0000);
		chk(q, 32'h0000_0000); // unmapped place reads zero
		wb(1'b1, cdps_pkg::ADR_MASK, 32'h0000_000f);
		// vpp request walks all eight codes under each switch type
		for (int i = 0; i < 18; i++) begin
			s = (i > 8);
			k = CARDS[i % 9];
			p = i[2:0];
			wb(1'b1, cdps_pkg::ADR_CTRL, {21'h00_0000, s, 10'h000});
			present <= 1'b1;
			card <= k;
			wait_ev(cdps_pkg::EV_DETECT);
			chk(ev[cdps_pkg::EV_INSERT], 1'b1);
			wb(1'b0, cdps_pkg::ADR_PRESENT, 32'h0000_0000);
			chk(q[3:0], k[3:0]);
			chk(q[cdps_pkg::PRES_LV], !s && k[3:0] == 4'h5);
			chk(q[cdps_pkg::PRES_XV], s && k[3:0] == 4'h5);
			chk({pu, pd}, (k[3:0] == 4'h1) ? 2'h2 : 2'h1);
			r = rnd();
			wb(1'b1, cdps_pkg::ADR_POWER, {23'h00_0000, 1'b1, 1'b0, p, 2'h0, r[1:0]});
			wb(1'b0, cdps_pkg::ADR_POWER, 32'h0000_0000);
			chk(q, {23'h00_0000, 1'b1, 1'b0, p, 2'h0, r[1:0]});
			wait_ev(cdps_pkg::EV_SENT);
			chk(word, exp_word(s, p, r[1:0], 1'b1));
			present <= 1'b0;
			wait_ev(cdps_pkg::EV_SENT);
			chk(ev[cdps_pkg::EV_REMOVE], 1'b1);
			chk(word, exp_word(s, p, r[1:0], 1'b0));
		end
		test_done();
	end
endmodule
bind cdps_top cdps_checker i_chk (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .WB_DAT_O,
	.CARD_DETECT_A_O, .CARD_DETECT_B_O, .CARD_DETECT_A_OE, .CARD_DETECT_B_OE,
	.STATUS_CHANGE_PULLUP, .STATUS_CHANGE_PULLDOWN,
	.SW_CLK, .SW_DATA, .SW_LATCH);
